// ==== hw/flash_isp_command_handler.sv ====
// flash in-system programming command handler: serial link and boot entries
`timescale 1ns/10ps

// Operation
// - command 0x3B plus one byte loads the flash write timing register
// - command 0xB3 plus page address erases that page
// - command 0xBF plus one byte, whose value is not checked, erases all flash
// - 0x1D reads a byte; 0xFF when secured; 0xFFFF gives option register
// - block read of n bytes, up to 32767, all ones when secured
// - command 0x71 with address and data programs one byte
// - exit 0xD3 resets device to flash when boot-select bit is one
// - unknown command bytes are ignored without effect
// - when secured only mass erase, timing write, byte read run
// - called mass erase needs 0x55 in accumulator, then serial mode
// - write byte from 0xAB; read routine returns byte at 0xAA
// - block count at 0xF1, reads 0..255, data at index pointer
// - interrupts blocked during routines, enable bit kept unchanged
// - watchdog serviced during routines and once more on return
// - correct 6-bit key sets key-valid for 8 cycles; jump needs it
// - wrong key leaves flag clear; jump goes to flash target
module flash_isp_command_handler #(
  parameter int AW = 16
) (
  // clocks and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  // serial link, link clock domain
  input wire logic LINK_DATA_I,
  output logic LINK_DATA_O,
  // cpu ram-mapped register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // keyed jump from the cpu
  input wire logic JUMP_I,
  input wire logic [7:0] JUMP_ENTRY_I,
  input wire logic [7:0] ACC_I,
  input wire logic [7:0] INDEX_PTR_I,
  output logic JUMP_BOOT_O,
  output logic JUMP_FLASH_O,
  // cpu ram for block transfers
  output logic RAM_WR_O,
  output logic [7:0] RAM_ADDR_O,
  output logic [7:0] RAM_WDATA_O,
  input wire logic [7:0] RAM_RDATA_I,
  // flash array port
  output logic FLASH_REQ_O,
  output logic [1:0] FLASH_OP_O,
  output logic [AW-1:0] FLASH_ADDR_O,
  output logic [7:0] FLASH_WDATA_O,
  input wire logic FLASH_DONE_I,
  input wire logic [7:0] FLASH_RDATA_I,
  // option and system status
  input wire logic SECURE_I,
  input wire logic BOOT_SEL_I,
  input wire logic [7:0] OPTION_I,
  output logic IRQ_BLOCK_O,
  output logic WDOG_SERVICE_O,
  output logic SERIAL_MODE_O,
  output logic DEVICE_RESET_O
);

  // ------------------------------------------------------------
  // link domain: byte shifter, toggle handshakes to and from the core
  // ------------------------------------------------------------
  logic [2:0] lbit_reg;
  logic [7:0] lshift_reg;
  logic [7:0] lbyte_reg;
  logic ltog_reg;
  logic [7:0] ltx_reg;
  logic [7:0] tx_hold_reg;
  logic tx_tog_reg;
  logic [1:0] ltx_sync_reg;
  logic ltx_seen_reg;
  logic [1:0] ld_sync_reg;
  logic ld;
  wire logic [7:0] lshift_next = {lshift_reg[6:0], ld};
  wire logic tx_load = (lbit_reg == 3'h7);

  // data pin synchronised into the link clock before use
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) ld_sync_reg <= 2'h0;
    else ld_sync_reg <= {ld_sync_reg[0], LINK_DATA_I};
  end
  assign ld = ld_sync_reg[1];

  // receive msb first; toggle marks each byte to the core
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lbit_reg <= 3'h6; // frames each byte behind the two sync stages
      lshift_reg <= 8'h00;
      lbyte_reg <= 8'h00;
      ltog_reg <= 1'b0;
    end else begin
      lbit_reg <= lbit_reg + 3'h1;
      lshift_reg <= lshift_next;
      if (tx_load) begin
        lbyte_reg <= lshift_next;
        ltog_reg <= ~ltog_reg;
      end
    end
  end

  // transmit shifter; reply word is held stable by the core across the crossing
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ltx_reg <= isp_pkg::BLANK_BYTE;
      ltx_sync_reg <= 2'h0;
      ltx_seen_reg <= 1'b0;
      LINK_DATA_O <= 1'b1;
    end else begin
      ltx_sync_reg <= {ltx_sync_reg[0], tx_tog_reg};
      LINK_DATA_O <= ltx_reg[7];
      if (tx_load && (ltx_sync_reg[1] != ltx_seen_reg)) begin
        ltx_reg <= tx_hold_reg;
        ltx_seen_reg <= ltx_sync_reg[1];
      end else if (tx_load) ltx_reg <= isp_pkg::BLANK_BYTE;
      else ltx_reg <= {ltx_reg[6:0], 1'b1};
    end
  end

  // ------------------------------------------------------------
  // core domain: byte arrival, registers, key
  // ------------------------------------------------------------
  logic [2:0] rx_sync_reg;
  wire logic rx_ev = rx_sync_reg[2] ^ rx_sync_reg[1];
  logic [7:0] rx_byte_reg;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_sync_reg <= 3'h0;
      rx_byte_reg <= isp_pkg::RESET_BYTE;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], ltog_reg};
      if (rx_ev) rx_byte_reg <= lbyte_reg; // stable for eight link bits
    end
  end

  logic [7:0] addr_lo_reg, addr_hi_reg, rd_res_reg, wr_src_reg, timing_reg, count_reg;
  logic [3:0] key_cnt_reg;
  wire logic key_valid = (key_cnt_reg != 4'h0);
  wire logic wr_lo = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_FLASH_LOW);
  wire logic wr_hi = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_FLASH_HIGH);
  wire logic wr_rd = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_READ_RESULT);
  wire logic wr_src = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_WRITE_SOURCE);
  wire logic wr_tim = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_TIMING);
  wire logic wr_cnt = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_BYTE_COUNT);
  wire logic wr_key = REG_WR_I && (REG_ADDR_I == isp_pkg::ADR_JUMP_KEY);
  wire logic key_ok = wr_key && (REG_WDATA_I[7:2] == isp_pkg::KEY_VALUE);

  // key window counts down once per cycle
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) key_cnt_reg <= 4'h0;
    else if (key_ok) key_cnt_reg <= isp_pkg::KEY_LIFE;
    else if (wr_key) key_cnt_reg <= 4'h0;
    else if (key_valid) key_cnt_reg <= key_cnt_reg - 4'h1;
  end

  // readback mux; the key location reads as zero
  wire logic [7:0] rd_mux =
    (REG_ADDR_I == isp_pkg::ADR_FLASH_LOW) ? addr_lo_reg :
    (REG_ADDR_I == isp_pkg::ADR_FLASH_HIGH) ? addr_hi_reg :
    (REG_ADDR_I == isp_pkg::ADR_READ_RESULT) ? rd_res_reg :
    (REG_ADDR_I == isp_pkg::ADR_WRITE_SOURCE) ? wr_src_reg :
    (REG_ADDR_I == isp_pkg::ADR_TIMING) ? timing_reg :
    (REG_ADDR_I == isp_pkg::ADR_BYTE_COUNT) ? count_reg : isp_pkg::RESET_BYTE;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_P1, S_P2, S_P3, S_P4, S_FLASH, S_FWAIT,
    S_REPLY, S_RAMRD, S_EXIT, S_PACE
  } state_e;
  state_e state_reg;
  logic serial_reg; // serial command mode
  logic [7:0] cmd_reg;
  logic [15:0] left_reg;
  logic [7:0] ptr_reg;
  logic user_reg; // current op came from a called entry
  logic [15:0] faddr;
  assign faddr = {addr_hi_reg, addr_lo_reg};
  wire logic secure_skip = SECURE_I && (cmd_reg != isp_pkg::CMD_MASS_ERASE)
    && (cmd_reg != isp_pkg::CMD_SET_TIMING) && (cmd_reg != isp_pkg::CMD_READ_BYTE);
  wire logic known = (rx_byte_reg == isp_pkg::CMD_SET_TIMING)
    || (rx_byte_reg == isp_pkg::CMD_PAGE_ERASE) || (rx_byte_reg == isp_pkg::CMD_MASS_ERASE)
    || (rx_byte_reg == isp_pkg::CMD_READ_BYTE) || (rx_byte_reg == isp_pkg::CMD_MULTI_READ)
    || (rx_byte_reg == isp_pkg::CMD_WRITE_BYTE) || (rx_byte_reg == isp_pkg::CMD_MULTI_WRITE)
    || (rx_byte_reg == isp_pkg::CMD_EXIT);
  wire logic jump_boot = JUMP_I && key_valid;
  logic rx_ev_d_reg;
  logic rd_wait_reg; // one flash read in flight
  wire logic byte_in = rx_ev_d_reg;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) rx_ev_d_reg <= 1'b0;
    else rx_ev_d_reg <= rx_ev && serial_reg;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= S_IDLE;
      serial_reg <= 1'b0;
      {cmd_reg, ptr_reg} <= 16'h0000;
      left_reg <= 16'h0000;
      user_reg <= 1'b0;
      {addr_lo_reg, addr_hi_reg, rd_res_reg, wr_src_reg, timing_reg, count_reg} <= 48'h0;
      {FLASH_REQ_O, RAM_WR_O, JUMP_BOOT_O, JUMP_FLASH_O, DEVICE_RESET_O} <= 5'h0;
      {IRQ_BLOCK_O, WDOG_SERVICE_O} <= 2'h0;
      FLASH_OP_O <= isp_pkg::OP_WRITE;
      FLASH_ADDR_O <= '0;
      {FLASH_WDATA_O, RAM_WDATA_O, RAM_ADDR_O, REG_RDATA_O} <= 32'h0;
      tx_hold_reg <= isp_pkg::BLANK_BYTE;
      tx_tog_reg <= 1'b0;
      SERIAL_MODE_O <= 1'b0;
      rd_wait_reg <= 1'b0;
    end else begin
      FLASH_REQ_O <= 1'b0;
      RAM_WR_O <= 1'b0;
      JUMP_BOOT_O <= 1'b0;
      JUMP_FLASH_O <= 1'b0;
      WDOG_SERVICE_O <= 1'b0;
      REG_RDATA_O <= REG_RD_I ? rd_mux : isp_pkg::RESET_BYTE;
      if (wr_lo) addr_lo_reg <= REG_WDATA_I;
      if (wr_hi) addr_hi_reg <= REG_WDATA_I;
      if (wr_rd) rd_res_reg <= REG_WDATA_I;
      if (wr_src) wr_src_reg <= REG_WDATA_I;
      if (wr_tim) timing_reg <= REG_WDATA_I;
      if (wr_cnt) count_reg <= REG_WDATA_I;
      SERIAL_MODE_O <= serial_reg;
      unique case (state_reg)
        S_IDLE: begin
          IRQ_BLOCK_O <= serial_reg;
          if (serial_reg) begin
            if (byte_in) begin
              cmd_reg <= rx_byte_reg;
              state_reg <= known ? S_CMD : S_IDLE;
            end
          end else if (JUMP_I && !key_valid) JUMP_FLASH_O <= 1'b1;
          else if (jump_boot) begin
            IRQ_BLOCK_O <= 1'b1;
            WDOG_SERVICE_O <= 1'b1;
            user_reg <= 1'b1;
            JUMP_BOOT_O <= 1'b1;
            ptr_reg <= INDEX_PTR_I;
            RAM_ADDR_O <= INDEX_PTR_I;
            left_reg <= {8'h00, count_reg};
            FLASH_ADDR_O <= faddr[AW-1:0];
            FLASH_WDATA_O <= wr_src_reg;
            state_reg <= S_FLASH;
            if (JUMP_ENTRY_I == isp_pkg::ENT_WRITE_BYTE) begin
              FLASH_OP_O <= isp_pkg::OP_WRITE;
              left_reg <= 16'h0001;
            end else if (JUMP_ENTRY_I == isp_pkg::ENT_PAGE_ERASE) begin
              FLASH_OP_O <= isp_pkg::OP_PAGE;
              left_reg <= 16'h0001;
            end else if (JUMP_ENTRY_I == isp_pkg::ENT_MASS_ERASE
                && ACC_I == isp_pkg::MASS_CONFIRM) begin
              FLASH_OP_O <= isp_pkg::OP_MASS;
              left_reg <= 16'h0001;
            end else if (JUMP_ENTRY_I == isp_pkg::ENT_BLOCK_WRITE) state_reg <= S_RAMRD;
            else if (JUMP_ENTRY_I == isp_pkg::ENT_READ_BYTE
                || JUMP_ENTRY_I == isp_pkg::ENT_BLOCK_READ) begin
              FLASH_OP_O <= isp_pkg::OP_WRITE;
              cmd_reg <= JUMP_ENTRY_I;
              state_reg <= S_REPLY;
              if (JUMP_ENTRY_I == isp_pkg::ENT_READ_BYTE) left_reg <= 16'h0001;
            end else if (JUMP_ENTRY_I == isp_pkg::ENT_LINK_MODE) begin
              serial_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else state_reg <= S_EXIT;
          end
        end
        S_CMD: begin
          left_reg <= 16'h0000;
          user_reg <= 1'b0;
          state_reg <= (secure_skip || cmd_reg == isp_pkg::CMD_EXIT) ? S_EXIT : S_P1;
          if (secure_skip) state_reg <= S_IDLE;
        end
        S_P1: if (byte_in) begin
          if (cmd_reg == isp_pkg::CMD_SET_TIMING) begin
            timing_reg <= rx_byte_reg;
            state_reg <= S_IDLE;
          end else if (cmd_reg == isp_pkg::CMD_MASS_ERASE) begin
            FLASH_OP_O <= isp_pkg::OP_MASS;
            left_reg <= 16'h0001;
            state_reg <= S_FLASH;
          end else begin
            addr_hi_reg <= rx_byte_reg;
            state_reg <= S_P2;
          end
        end
        S_P2: if (byte_in) begin
          addr_lo_reg <= rx_byte_reg;
          left_reg <= 16'h0001;
          FLASH_ADDR_O <= {addr_hi_reg, rx_byte_reg};
          if (cmd_reg == isp_pkg::CMD_PAGE_ERASE) begin
            FLASH_OP_O <= isp_pkg::OP_PAGE;
            state_reg <= S_FLASH;
          end else if (cmd_reg == isp_pkg::CMD_READ_BYTE) state_reg <= S_REPLY;
          else state_reg <= S_P3;
        end
        S_P3: if (byte_in) begin
          FLASH_WDATA_O <= rx_byte_reg;
          if (cmd_reg == isp_pkg::CMD_WRITE_BYTE) begin
            FLASH_OP_O <= isp_pkg::OP_WRITE;
            state_reg <= S_FLASH;
          end else if (cmd_reg == isp_pkg::CMD_MULTI_WRITE) begin
            left_reg <= {8'h00, rx_byte_reg};
            FLASH_OP_O <= isp_pkg::OP_WRITE;
            state_reg <= (rx_byte_reg == 8'h00) ? S_IDLE : S_P4;
          end else begin
            left_reg <= {rx_byte_reg, 8'h00};
            state_reg <= S_P4;
          end
        end
        S_P4: if (byte_in) begin
          if (cmd_reg == isp_pkg::CMD_MULTI_WRITE) begin
            FLASH_WDATA_O <= rx_byte_reg;
            state_reg <= S_FLASH;
          end else begin
            left_reg <= {left_reg[15:8], rx_byte_reg} & isp_pkg::MAX_BLOCK_READ;
            state_reg <= ({left_reg[15:8], rx_byte_reg} == 16'h0000) ? S_IDLE : S_REPLY;
          end
        end
        S_RAMRD: begin
          if (left_reg == 16'h0000) state_reg <= S_EXIT;
          else begin
            FLASH_WDATA_O <= RAM_RDATA_I;
            FLASH_OP_O <= isp_pkg::OP_WRITE;
            state_reg <= S_FLASH;
          end
        end
        S_FLASH: begin
          FLASH_REQ_O <= 1'b1;
          state_reg <= S_FWAIT;
        end
        S_FWAIT: if (FLASH_DONE_I) begin
          left_reg <= left_reg - 16'h0001;
          FLASH_ADDR_O <= FLASH_ADDR_O + 1'b1;
          ptr_reg <= ptr_reg + 8'h01;
          WDOG_SERVICE_O <= user_reg;
          RAM_ADDR_O <= ptr_reg + 8'h01; // ram data settles before S_RAMRD reads it
          if (FLASH_OP_O == isp_pkg::OP_MASS && user_reg) begin
            serial_reg <= 1'b1;
            user_reg <= 1'b0;
            state_reg <= S_IDLE;
          end else if (left_reg == 16'h0001) state_reg <= user_reg ? S_EXIT : S_IDLE;
          else state_reg <= user_reg ? S_RAMRD : S_P4;
        end
        S_REPLY: begin
          if (left_reg == 16'h0000) state_reg <= user_reg ? S_EXIT : S_IDLE;
          else if (!rd_wait_reg) begin
            FLASH_REQ_O <= 1'b1; // one request per byte, then wait for done
            rd_wait_reg <= 1'b1;
          end
          if (FLASH_DONE_I && left_reg != 16'h0000) begin
            rd_wait_reg <= 1'b0;
            left_reg <= left_reg - 16'h0001;
            FLASH_ADDR_O <= FLASH_ADDR_O + 1'b1;
            if (user_reg) begin
              if (cmd_reg == isp_pkg::ENT_READ_BYTE) rd_res_reg <= FLASH_RDATA_I;
              else begin
                RAM_WR_O <= 1'b1;
                RAM_ADDR_O <= ptr_reg;
                RAM_WDATA_O <= FLASH_RDATA_I;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end else begin
              tx_tog_reg <= ~tx_tog_reg;
              if (cmd_reg == isp_pkg::CMD_READ_BYTE && FLASH_ADDR_O == isp_pkg::OPTION_ADDR)
                tx_hold_reg <= OPTION_I;
              else tx_hold_reg <= SECURE_I ? isp_pkg::BLANK_BYTE : FLASH_RDATA_I;
              state_reg <= S_PACE; // next byte paced by host clocking
              if (left_reg == 16'h0001) state_reg <= S_IDLE;
            end
          end
        end
        S_EXIT: begin
          if (!user_reg && BOOT_SEL_I) DEVICE_RESET_O <= 1'b1;
          WDOG_SERVICE_O <= 1'b1;
          IRQ_BLOCK_O <= 1'b0;
          user_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        S_PACE: if (byte_in) state_reg <= S_REPLY;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// ==== hw/isp_pkg.sv ====
// shared constants for the flash in-system programming command handler
package isp_pkg;
  // serial command codes
  localparam logic [7:0] CMD_SET_TIMING = 8'h3B;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'hB3;
  localparam logic [7:0] CMD_MASS_ERASE = 8'hBF;
  localparam logic [7:0] CMD_READ_BYTE = 8'h1D;
  localparam logic [7:0] CMD_MULTI_READ = 8'h43;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h71;
  localparam logic [7:0] CMD_MULTI_WRITE = 8'h8F;
  localparam logic [7:0] CMD_EXIT = 8'hD3;
  // boot entry points
  localparam logic [7:0] ENT_LINK_MODE = 8'h00;
  localparam logic [7:0] ENT_READ_BYTE = 8'h11;
  localparam logic [7:0] ENT_WRITE_BYTE = 8'h14;
  localparam logic [7:0] ENT_PAGE_ERASE = 8'h17;
  localparam logic [7:0] ENT_MASS_ERASE = 8'h1A;
  localparam logic [7:0] ENT_BLOCK_WRITE = 8'h23;
  localparam logic [7:0] ENT_BLOCK_READ = 8'h26;
  localparam logic [7:0] ENT_EXIT = 8'h62;
  // ram-mapped register locations
  localparam logic [7:0] ADR_FLASH_LOW = 8'hA8;
  localparam logic [7:0] ADR_FLASH_HIGH = 8'hA9;
  localparam logic [7:0] ADR_READ_RESULT = 8'hAA;
  localparam logic [7:0] ADR_WRITE_SOURCE = 8'hAB;
  localparam logic [7:0] ADR_TIMING = 8'hE1;
  localparam logic [7:0] ADR_JUMP_KEY = 8'hE2;
  localparam logic [7:0] ADR_BYTE_COUNT = 8'hF1;
  // key, confirmation and other fixed values
  localparam logic [5:0] KEY_VALUE = 6'h26; // 0x98 >> 2
  localparam logic [7:0] MASS_CONFIRM = 8'h55;
  localparam logic [3:0] KEY_LIFE = 4'h8;
  localparam logic [15:0] OPTION_ADDR = 16'hFFFF;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] MAX_BLOCK_READ = 16'h7FFF;
  localparam logic [7:0] MAX_BLOCK_WRITE = 8'h10;
  // flash operation codes towards the array
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_PAGE = 2'h1;
  localparam logic [1:0] OP_MASS = 2'h2;
endpackage

// ==== tb/flash_isp_command_handler_bench.sv ====
// self-checking bench for the flash programming command handler
`timescale 1ns/10ps
module flash_isp_command_handler_bench;
  logic clk, rst, lclk, ldi, ldo, reg_wr, reg_rd, jump, jboot, jflash, ram_wr, freq, fdone;
  logic secure, irq_blk, wdog, ser_mode, dev_rst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, jentry, acc, ram_addr, ram_wdata, fwdata, rdata;
  logic [7:0] last_data, adrs [5];
  logic [1:0] fop, last_op, res;
  logic [15:0] faddr, last_addr;
  logic [31:0] seen;
  int miscompares, checks_done, reqs, fcnt, n0;
  flash_isp_command_handler i_flash_isp_command_handler (
    .CORE_CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk), .LINK_DATA_I(ldi), .LINK_DATA_O(ldo),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_RDATA_O(reg_rdata), .JUMP_I(jump), .JUMP_ENTRY_I(jentry), .ACC_I(acc),
    .INDEX_PTR_I(8'h40), .JUMP_BOOT_O(jboot), .JUMP_FLASH_O(jflash), .RAM_WR_O(ram_wr),
    .RAM_ADDR_O(ram_addr), .RAM_WDATA_O(ram_wdata), .RAM_RDATA_I(ram_addr ^ 8'h3C),
    .FLASH_REQ_O(freq), .FLASH_OP_O(fop), .FLASH_ADDR_O(faddr), .FLASH_WDATA_O(fwdata),
    .FLASH_DONE_I(fdone), .FLASH_RDATA_I(faddr[7:0] ^ 8'h5A), .SECURE_I(secure),
    .BOOT_SEL_I(1'b1), .OPTION_I(8'hC3), .IRQ_BLOCK_O(irq_blk), .WDOG_SERVICE_O(wdog),
    .SERIAL_MODE_O(ser_mode), .DEVICE_RESET_O(dev_rst));
  isp_link_host i_isp_link_host (.rst_i(rst), .link_clk_o(lclk), .link_data_o(ldi),
    .link_data_i(ldo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // flash array: done three cycles after each request
  always @(posedge clk) begin
    fdone <= (fcnt == 1);
    if (fcnt != 0) fcnt <= fcnt - 1;
    if (freq === 1'b1) begin
      reqs <= reqs + 1;
      last_op <= fop;
      last_addr <= faddr;
      last_data <= fwdata;
      fcnt <= 3;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata;
  endtask
  // jump on the edge right after the key write, so the key is one cycle old
  task automatic jmp(input logic [7:0] e, input logic [7:0] a);
    jump <= 1'b1;
    jentry <= e;
    acc <= a;
    @(posedge clk);
    jump <= 1'b0;
    #1 res = {jboot, jflash};
  endtask
  task automatic call(input logic [7:0] key, input logic [7:0] e, input logic [7:0] a);
    wr_reg(isp_pkg::ADR_JUMP_KEY, key);
    jmp(e, a);
    for (int i = 0; i < 200 && irq_blk !== 1'b0; i++) @(posedge clk);
  endtask
  function automatic logic has_byte(input logic [31:0] s, input logic [7:0] b);
    has_byte = 1'b0;
    for (int i = 0; i <= 24; i++) if (s[i+:8] === b) has_byte = 1'b1;
  endfunction
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst, reg_wr, reg_rd, jump, secure, fdone} = 6'b100000;
    {reg_addr, reg_wdata, jentry, acc} = '0;
    {miscompares, checks_done, reqs, fcnt} = '0;
    adrs = '{8'hA8, 8'hA9, 8'hAB, 8'hE1, 8'hF1};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) wr_reg(adrs[i], 8'h21 + 8'(i * 17));
    for (int i = 0; i < 5; i++) begin
      rd_reg(adrs[i]);
      check(rdata, 8'h21 + 8'(i * 17));
    end
    $display("test registers done");
    call(8'h9B, isp_pkg::ENT_WRITE_BYTE, 8'h00); // low key bits are don't-care
    check(res, 2'b10);
    check({last_op, last_addr, last_data}, {2'h0, 16'h3221, 8'h43});
    call(8'h98, isp_pkg::ENT_READ_BYTE, 8'h00);
    rd_reg(isp_pkg::ADR_READ_RESULT);
    check(rdata, 8'h21 ^ 8'h5A);
    call(8'h98, isp_pkg::ENT_PAGE_ERASE, 8'h00);
    check(last_op, isp_pkg::OP_PAGE);
    wr_reg(isp_pkg::ADR_BYTE_COUNT, 8'h02);
    call(8'h98, isp_pkg::ENT_BLOCK_WRITE, 8'h00);
    check({last_addr, last_data}, {16'h3222, 8'h41 ^ 8'h3C});
    call(8'h9C, isp_pkg::ENT_PAGE_ERASE, 8'h00);
    check(res, 2'b01);
    wr_reg(isp_pkg::ADR_JUMP_KEY, 8'h98);
    repeat (8) @(posedge clk);
    jmp(isp_pkg::ENT_PAGE_ERASE, 8'h00);
    check(res, 2'b01);
    n0 = reqs;
    call(8'h98, isp_pkg::ENT_MASS_ERASE, 8'h54);
    check(reqs, n0);
    call(8'h98, isp_pkg::ENT_MASS_ERASE, 8'h55);
    check({last_op, ser_mode}, {isp_pkg::OP_MASS, 1'b1});
    $display("test keyed calls done");
    i_isp_link_host.xfer(32'h3B17_FFFF, seen); // timing load first
    rd_reg(isp_pkg::ADR_TIMING);
    check(rdata, 8'h17);
    n0 = reqs;
    i_isp_link_host.xfer(32'h00FF_FFFF, seen);
    check(reqs, n0);
    i_isp_link_host.xfer(32'h7112_34AB, seen);
    check({last_op, last_addr, last_data}, {2'h0, 16'h1234, 8'hAB});
    i_isp_link_host.xfer(32'hB312_00FF, seen);
    check({last_op, last_addr}, {isp_pkg::OP_PAGE, 16'h1200});
    i_isp_link_host.xfer(32'h8F12_4001, seen);
    check({last_op, last_addr, last_data}, {2'h0, 16'h1240, 8'hFF});
    i_isp_link_host.xfer(32'h1D00_12FF, seen);
    check(has_byte(seen, 8'h48), 1'b1);
    @(posedge clk);
    secure <= 1'b1;
    i_isp_link_host.xfer(32'h1D00_12FF, seen);
    check(seen, 32'hFFFF_FFFF);
    i_isp_link_host.xfer(32'h1DFF_FFFF, seen);
    check(has_byte(seen, 8'hC3), 1'b1);
    n0 = reqs;
    i_isp_link_host.xfer(32'h7112_34AB, seen);
    check(reqs, n0);
    i_isp_link_host.xfer(32'hD3FF_FFFF, seen);
    check(dev_rst, 1'b0);
    @(posedge clk);
    secure <= 1'b0;
    i_isp_link_host.xfer(32'hD3FF_FFFF, seen);
    for (int i = 0; i < 200 && dev_rst !== 1'b1; i++) @(posedge clk);
    check(dev_rst, 1'b1);
    $display("test serial link done");
    print_verdict;
  end
  // hang guard, far beyond the time the tests need
  initial begin
    #2000000;
    miscompares++;
    print_verdict;
  end
endmodule

// ==== tb/isp_handler_props.sv ====
// port checker for the flash programming command handler
`timescale 1ns/10ps
module isp_handler_props #(
  parameter int AW = 16
) (
  // clock, reset, cpu side
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic JUMP_I,
  input wire logic [7:0] JUMP_ENTRY_I,
  input wire logic [7:0] ACC_I,
  // answers
  input wire logic JUMP_BOOT_O,
  input wire logic JUMP_FLASH_O,
  input wire logic FLASH_REQ_O,
  input wire logic [1:0] FLASH_OP_O,
  input wire logic [AW-1:0] FLASH_ADDR_O,
  input wire logic IRQ_BLOCK_O,
  input wire logic WDOG_SERVICE_O,
  input wire logic DEVICE_RESET_O
);
  logic [3:0] age_reg;
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  wire key_wr = REG_WR_I && REG_ADDR_I == isp_pkg::ADR_JUMP_KEY;
  wire key_good = key_wr && REG_WDATA_I[7:2] == isp_pkg::KEY_VALUE;
  // cycles since a good key; saturates so an old key stays stale
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      age_reg <= 4'hF;
    end else if (key_good) begin
      age_reg <= 4'h1;
    end else if (age_reg != 4'hF) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  // flash address as the cpu last wrote it
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hi_reg <= 8'h00;
      lo_reg <= 8'h00;
    end else if (REG_WR_I && REG_ADDR_I == isp_pkg::ADR_FLASH_HIGH) begin
      hi_reg <= REG_WDATA_I;
    end else if (REG_WR_I && REG_ADDR_I == isp_pkg::ADR_FLASH_LOW) begin
      lo_reg <= REG_WDATA_I;
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  chk_key_boot: assert property (key_good ##1 JUMP_I |=> JUMP_BOOT_O && !JUMP_FLASH_O)
    else $error("keyed jump refused");
  chk_key_stale: assert property (JUMP_I && age_reg >= 4'h9 |=> JUMP_FLASH_O)
    else $error("stale key accepted");
  chk_key_bad: assert property (key_wr && !key_good ##1 JUMP_I |=> JUMP_FLASH_O)
    else $error("bad key accepted");
  chk_write_req: assert property (JUMP_BOOT_O && $past(JUMP_ENTRY_I) == isp_pkg::ENT_WRITE_BYTE
    |=> FLASH_REQ_O && FLASH_OP_O == isp_pkg::OP_WRITE && FLASH_ADDR_O == AW'({hi_reg, lo_reg}))
    else $error("byte write request wrong");
  chk_page_req: assert property (JUMP_BOOT_O && $past(JUMP_ENTRY_I) == isp_pkg::ENT_PAGE_ERASE
    |=> FLASH_REQ_O && FLASH_OP_O == isp_pkg::OP_PAGE) else $error("page erase request wrong");
  chk_mass_refuse: assert property (JUMP_BOOT_O && $past(ACC_I) != isp_pkg::MASS_CONFIRM
    && $past(JUMP_ENTRY_I) == isp_pkg::ENT_MASS_ERASE |=> !FLASH_REQ_O [*4])
    else $error("mass erase without confirmation");
  chk_irq_block: assert property (JUMP_BOOT_O |-> IRQ_BLOCK_O)
    else $error("interrupts not blocked");
  chk_wdog_entry: assert property (JUMP_BOOT_O |-> WDOG_SERVICE_O)
    else $error("watchdog not serviced");
  chk_reset_holds: assert property ($rose(DEVICE_RESET_O) |=> DEVICE_RESET_O [*4])
    else $error("device reset dropped");
endmodule
bind flash_isp_command_handler isp_handler_props #(.AW(AW)) i_isp_handler_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .JUMP_I(JUMP_I), .JUMP_ENTRY_I(JUMP_ENTRY_I), .ACC_I(ACC_I),
  .JUMP_BOOT_O(JUMP_BOOT_O), .JUMP_FLASH_O(JUMP_FLASH_O), .FLASH_REQ_O(FLASH_REQ_O),
  .FLASH_OP_O(FLASH_OP_O), .FLASH_ADDR_O(FLASH_ADDR_O), .IRQ_BLOCK_O(IRQ_BLOCK_O),
  .WDOG_SERVICE_O(WDOG_SERVICE_O), .DEVICE_RESET_O(DEVICE_RESET_O));

// ==== tb/isp_link_host.sv ====
// behavioural host programmer on the serial link
`timescale 1ns/10ps
module isp_link_host (
  // reset keeps the clock alive
  input wire logic rst_i,
  // serial link
  output logic link_clk_o,
  output logic link_data_o,
  input wire logic link_data_i
);
  logic run;
  // 80 ns link clock, parked low between frames
  initial begin
    link_clk_o = 1'b0;
    link_data_o = 1'b1;
    run = 1'b0;
    #13;
    forever begin
      #40;
      if (run || rst_i || link_clk_o) link_clk_o = ~link_clk_o;
    end
  end
  // four bytes msb first, then four idle-high slots catching the reply
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] seen);
    seen = '1;
    run = 1'b1;
    for (int i = 0; i < 64; i++) begin
      link_data_o = (i < 32) ? cmd[31-i] : 1'b1;
      @(posedge link_clk_o);
      if (i >= 32) seen = {seen[30:0], link_data_i};
      @(negedge link_clk_o);
    end
    run = 1'b0;
  endtask
endmodule
